// ==== rlis_link_core.sv ====
// link core start-up: config register, comma transmit, receive sync and status
`timescale 1ns/1ns
`include "rlis_defines.svh"
module rlis_link_core #(
  parameter int CHANNELS = `RLIS_CHANNELS,
  parameter int LOCK_COMMAS = `RLIS_LOCK_COMMAS,
  parameter int LOSS_CYCLES = `RLIS_LOSS_CYCLES,
  parameter int HFN_CYCLES = `RLIS_HFN_CYCLES,
  parameter int BFN_CYCLES = `RLIS_BFN_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_link_reset,
  input wire logic i_config_reset,
  input wire logic i_cpu_reset,
  input wire logic i_delay_measure_reset,
  input wire logic [CHANNELS-1:0] i_channel_tx_reset,
  input wire logic [CHANNELS-1:0] i_channel_rx_reset,
  input wire logic i_powerdown,
  input wire logic [`RLIS_ADDR_W-1:0] i_cpu_address,
  input wire logic i_cpu_write,
  input wire logic i_cpu_read,
  input wire logic [31:0] i_cpu_writedata,
  output logic [31:0] o_cpu_readdata,
  output logic o_cpu_readvalid,
  input wire rlis_pkg::rlis_symbol_s i_rx_symbol,
  output rlis_pkg::rlis_symbol_s o_tx_symbol,
  output rlis_pkg::rlis_ext_status_s o_ext_rx_status,
  output logic o_link_ready,
  output logic o_delay_measure_ready,
  output logic [CHANNELS-1:0] o_channel_tx_ready,
  output logic [CHANNELS-1:0] o_channel_rx_ready
);
  import rlis_pkg::*;

  localparam int PIN_W = 5 + 2 * CHANNELS + $bits(rlis_symbol_s);
  localparam int CNT_W = 16;

  if (CHANNELS < 1 || LOCK_COMMAS < 2 || LOSS_CYCLES < 2 || HFN_CYCLES < 1 || BFN_CYCLES < 1 ||
      LOSS_CYCLES >= 2 ** CNT_W || HFN_CYCLES + BFN_CYCLES >= 2 ** CNT_W || LOCK_COMMAS >= 2 ** CNT_W) begin : g_bad
    $error("rlis_link_core: parameter out of range");
  end

  // pins from the sequencer and the line arrive from another domain
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_powerdown, i_link_reset, i_config_reset, i_cpu_reset, i_delay_measure_reset,
                   i_channel_tx_reset, i_channel_rx_reset, i_rx_symbol};
      pin_sync <= pin_meta;
    end
  end

  logic pd_s, link_rst_s, cfg_rst_s, cpu_rst_s, dm_rst_s;
  logic [CHANNELS-1:0] ch_tx_rst_s, ch_rx_rst_s;
  rlis_symbol_s rx_sym_s;
  assign {pd_s, link_rst_s, cfg_rst_s, cpu_rst_s, dm_rst_s, ch_tx_rst_s, ch_rx_rst_s, rx_sym_s} = pin_sync;

  // power-down resets the line side along with the link reset
  logic line_rst;
  assign line_rst = link_rst_s | pd_s;

  function automatic logic is_comma(input rlis_symbol_s s);
    is_comma = s.is_k && s.data == `RLIS_COMMA;
  endfunction : is_comma

  // processor port
  logic [31:0] link_cfg, next_link_cfg;
  logic [31:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  rlis_ext_status_s status, next_status;

  always_comb begin
    next_link_cfg = link_cfg;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    if (cfg_rst_s) begin
      next_link_cfg = `RLIS_LINK_CFG_RESET;
    end else if (i_cpu_write && !cpu_rst_s && i_cpu_address == `RLIS_LINK_CFG_OFFSET) begin
      next_link_cfg = i_cpu_writedata;
    end
    if (cpu_rst_s) begin
      next_rdata = '0;
    end else if (i_cpu_read) begin
      next_rvalid = 1'b1;
      unique case (i_cpu_address)
        `RLIS_LINK_CFG_OFFSET: next_rdata = link_cfg;
        `RLIS_LINK_STATUS_OFFSET: next_rdata = {24'h00_0000, status};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_cfg <= `RLIS_LINK_CFG_RESET;
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      link_cfg <= next_link_cfg;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // loopback modes are stored but only "none" drives the line here
  logic cfg_tx_en, cfg_slave, cfg_no_loop;
  assign cfg_tx_en = link_cfg[`RLIS_CFG_TX_ENABLE] && link_cfg[`RLIS_CFG_CW_INSERT];
  assign cfg_slave = link_cfg[`RLIS_CFG_SLAVE];
  assign cfg_no_loop = link_cfg[`RLIS_CFG_LOOP_HI:`RLIS_CFG_LOOP_LO] == 2'h0;

  // receive synchronisation
  rlis_rx_state_e rx_state, next_rx_state;
  logic [CNT_W-1:0] comma_cnt, next_comma_cnt;
  logic [CNT_W-1:0] loss_cnt, next_loss_cnt;
  logic [CNT_W-1:0] init_cnt, next_init_cnt;
  logic hfn, next_hfn, bfn, next_bfn;
  logic rx_comma;
  assign rx_comma = is_comma(rx_sym_s);

  always_comb begin
    next_rx_state = rx_state;
    next_comma_cnt = comma_cnt;
    next_init_cnt = init_cnt;
    next_hfn = hfn;
    next_bfn = bfn;
    next_loss_cnt = rx_comma ? '0 : loss_cnt + 1'b1;
    if (line_rst || (rx_state != RLIS_RX_UNSYNC && loss_cnt == CNT_W'(LOSS_CYCLES - 1))) begin
      next_rx_state = RLIS_RX_UNSYNC;
      next_comma_cnt = '0;
      next_loss_cnt = '0;
      next_init_cnt = '0;
      next_hfn = 1'b0;
      next_bfn = 1'b0;
    end else begin
      unique case (rx_state)
        RLIS_RX_UNSYNC: begin
          if (rx_comma) begin
            next_rx_state = RLIS_RX_ACQUIRE;
            next_comma_cnt = CNT_W'(1);
          end
        end
        RLIS_RX_ACQUIRE: begin
          if (rx_comma) begin
            next_comma_cnt = comma_cnt + 1'b1;
            if (comma_cnt == CNT_W'(LOCK_COMMAS - 1)) begin
              next_rx_state = RLIS_RX_HF_SYNC;
            end
          end
        end
        RLIS_RX_HF_SYNC: begin
          // number fields settle in order: hyperframe first, basic frame after
          if (!bfn) begin
            next_init_cnt = init_cnt + 1'b1;
          end
          if (init_cnt == CNT_W'(HFN_CYCLES - 1)) begin
            next_hfn = 1'b1;
          end
          if (hfn && init_cnt == CNT_W'(HFN_CYCLES + BFN_CYCLES - 1)) begin
            next_bfn = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state <= RLIS_RX_UNSYNC;
      comma_cnt <= '0;
      loss_cnt <= '0;
      init_cnt <= '0;
      hfn <= 1'b0;
      bfn <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      comma_cnt <= next_comma_cnt;
      loss_cnt <= next_loss_cnt;
      init_cnt <= next_init_cnt;
      hfn <= next_hfn;
      bfn <= next_bfn;
    end
  end

  // transmit and registered status outputs
  rlis_symbol_s tx_sym, next_tx_sym;
  logic ready, next_ready, dm_ready, next_dm_ready;
  logic [CHANNELS-1:0] ch_tx_ready, next_ch_tx_ready, ch_rx_ready, next_ch_rx_ready;
  logic rx_locked;
  // a slave waits for the far end's first comma, so it never syncs on its own loopback
  assign rx_locked = rx_state != RLIS_RX_UNSYNC;

  always_comb begin
    next_tx_sym = '{data: `RLIS_IDLE, is_k: 1'b0};
    if (!line_rst && cfg_tx_en && cfg_no_loop && (!cfg_slave || rx_locked)) begin
      next_tx_sym = '{data: `RLIS_COMMA, is_k: 1'b1};
    end
    next_status.rx_state = next_rx_state;
    next_status.cnt_sync = next_rx_state == RLIS_RX_HF_SYNC ? `RLIS_CNT_SYNC_LOCKED : 3'h0;
    next_status.spare = 1'b0;
    next_status.hfn_valid = next_hfn;
    next_status.bfn_valid = next_bfn;
    next_ready = next_bfn;
    next_dm_ready = next_bfn && !dm_rst_s;
    next_ch_tx_ready = {CHANNELS{next_bfn}} & ~ch_tx_rst_s;
    next_ch_rx_ready = {CHANNELS{next_bfn}} & ~ch_rx_rst_s;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_sym <= '{data: `RLIS_IDLE, is_k: 1'b0};
      status <= '{rx_state: RLIS_RX_UNSYNC, default: '0};
      ready <= 1'b0;
      dm_ready <= 1'b0;
      ch_tx_ready <= '0;
      ch_rx_ready <= '0;
    end else begin
      tx_sym <= next_tx_sym;
      status <= next_status;
      ready <= next_ready;
      dm_ready <= next_dm_ready;
      ch_tx_ready <= next_ch_tx_ready;
      ch_rx_ready <= next_ch_rx_ready;
    end
  end

  assign o_cpu_readdata = rdata;
  assign o_cpu_readvalid = rvalid;
  assign o_tx_symbol = tx_sym;
  assign o_ext_rx_status = status;
  assign o_link_ready = ready;
  assign o_delay_measure_ready = dm_ready;
  assign o_channel_tx_ready = ch_tx_ready;
  assign o_channel_rx_ready = ch_rx_ready;
endmodule : rlis_link_core

// ==== rlis_defines.svh ====
// offsets, field positions, reset values and counts of the link start-up block
`ifndef RLIS_DEFINES_SVH
`define RLIS_DEFINES_SVH
`define RLIS_ADDR_W 14
`define RLIS_LINK_CFG_OFFSET 14'h0008
`define RLIS_LINK_STATUS_OFFSET 14'h000c
`define RLIS_LINK_CFG_RESET 32'h0000_0000
`define RLIS_CFG_TX_ENABLE 0
`define RLIS_CFG_LOOP_LO 2
`define RLIS_CFG_LOOP_HI 3
`define RLIS_CFG_SLAVE 4
`define RLIS_CFG_CW_INSERT 5
`define RLIS_COMMA 8'hbc
`define RLIS_IDLE 8'h00
`define RLIS_CNT_SYNC_LOCKED 3'h1
`define RLIS_LOCK_COMMAS 4
`define RLIS_LOSS_CYCLES 64
`define RLIS_HFN_CYCLES 16
`define RLIS_BFN_CYCLES 8
`define RLIS_CHANNELS 3
`endif

// ==== rlis_pkg.sv ====
// types shared by the link start-up block
package rlis_pkg;
  typedef enum logic [1:0] {
    RLIS_RX_UNSYNC = 2'h0,
    RLIS_RX_ACQUIRE = 2'h2,
    RLIS_RX_HF_SYNC = 2'h3
  } rlis_rx_state_e;

  typedef struct packed {
    logic hfn_valid;
    logic bfn_valid;
    logic spare;
    logic [2:0] cnt_sync;
    rlis_rx_state_e rx_state;
  } rlis_ext_status_s;

  typedef struct packed {
    logic [7:0] data;
    logic is_k;
  } rlis_symbol_s;
endpackage : rlis_pkg

// ==== rlis_link_core_sva.sv ====
// assertions on the link core ports
`timescale 1ns/1ns
module rlis_link_core_sva (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_cpu_read,
  input wire logic o_cpu_readvalid,
  input wire rlis_pkg::rlis_symbol_s o_tx_symbol,
  input wire rlis_pkg::rlis_ext_status_s o_ext_rx_status,
  input wire logic o_link_ready
);
  import rlis_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic hf;
  logic bfn;
  assign hf = o_ext_rx_status.rx_state == RLIS_RX_HF_SYNC;
  assign bfn = o_ext_rx_status.bfn_valid;
  AST_CNT: assert property (o_ext_rx_status.cnt_sync == (hf ? 3'h1 : 3'h0))
    else $error("sync count wrong");
  AST_STATE: assert property (o_ext_rx_status.rx_state != 2'h1)
    else $error("illegal receive state");
  AST_ORDER: assert property ($rose(hf) |-> $past(o_ext_rx_status.rx_state) == RLIS_RX_ACQUIRE)
    else $error("state skipped acquire");
  AST_HFN: assert property (o_ext_rx_status.hfn_valid |-> hf)
    else $error("hfn flag outside sync");
  AST_BFN: assert property ($rose(bfn) |-> $past(o_ext_rx_status.hfn_valid))
    else $error("bfn flag before hfn");
  AST_READY: assert property ($rose(o_link_ready) |-> bfn)
    else $error("ready without bfn");
  AST_READY_LOW: assert property (!bfn ##1 !bfn |-> !o_link_ready)
    else $error("ready stuck");
  AST_RVALID: assert property (i_cpu_read |=> o_cpu_readvalid)
    else $error("read not answered");
  AST_RVALID_ONE: assert property (!i_cpu_read |=> !o_cpu_readvalid)
    else $error("stray readvalid");
  AST_COMMA: assert property (o_tx_symbol.is_k |-> o_tx_symbol.data == 8'hbc)
    else $error("k symbol not comma");
  COV_SYNC: cover property ($rose(hf));
  COV_READY: cover property ($rose(o_link_ready));
  COV_READ: cover property (o_cpu_readvalid);
endmodule : rlis_link_core_sva
bind rlis_link_core rlis_link_core_sva rlis_link_core_sva_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_cpu_read(i_cpu_read), .o_cpu_readvalid(o_cpu_readvalid), .o_tx_symbol(o_tx_symbol),
  .o_ext_rx_status(o_ext_rx_status), .o_link_ready(o_link_ready));

// ==== rlis_far_end.sv ====
// far link end: commas on request, changing filler otherwise
`timescale 1ns/1ns
module rlis_far_end (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_send,
  output rlis_pkg::rlis_symbol_s o_symbol
);
  import rlis_pkg::*;
  logic [7:0] fill;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fill <= 8'h00;
      o_symbol <= '0;
    end else begin
      fill <= fill + 8'h01;
      // filler keeps moving so a stale line never looks steady
      o_symbol <= i_send ? '{data: 8'hbc, is_k: 1'b1} : '{data: fill, is_k: 1'b0};
    end
  end
endmodule : rlis_far_end

// ==== test_rlis_link_core.sv ====
// self-checking bench for the link core
`timescale 1ns/1ns
module test_rlis_link_core;
  import rlis_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic rst = 1'b1;
  logic send = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [13:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic rv;
  rlis_symbol_s rx;
  rlis_symbol_s tx;
  rlis_ext_status_s st;
  logic lr;
  logic dr;
  logic [2:0] txr;
  logic [2:0] rxr;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  always #5 i_clock = ~i_clock;
  rlis_link_core #(.CHANNELS(3), .LOCK_COMMAS(2), .LOSS_CYCLES(8), .HFN_CYCLES(2), .BFN_CYCLES(2))
    rlis_link_core_inst (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_link_reset(rst), .i_config_reset(rst),
    .i_cpu_reset(rst), .i_delay_measure_reset(rst), .i_channel_tx_reset({3{rst}}),
    .i_channel_rx_reset({3{rst}}), .i_powerdown(rst), .i_cpu_address(addr), .i_cpu_write(wr),
    .i_cpu_read(rd), .i_cpu_writedata(wdata), .o_cpu_readdata(rdata), .o_cpu_readvalid(rv),
    .i_rx_symbol(rx), .o_tx_symbol(tx), .o_ext_rx_status(st), .o_link_ready(lr),
    .o_delay_measure_ready(dr), .o_channel_tx_ready(txr), .o_channel_rx_ready(rxr));
  rlis_far_end rlis_far_end_inst (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_send(send), .o_symbol(rx));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic write_reg(input logic [13:0] a, input logic [31:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask : write_reg
  task automatic read_reg(input string n, input logic [13:0] a, input logic [31:0] e);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    chk("readvalid", 32'h1, {31'h0, rv});
    chk(n, e, rdata);
  endtask : read_reg
  task automatic wait_status(input logic [7:0] e);
    for (int n = 0; n < 40 && st !== e; n++) begin
      @(posedge i_clock);
      #1;
    end
    chk("status", {24'h0, e}, {24'h0, st});
  endtask : wait_status
  task automatic t_start();
    chk("status", 32'h0, {24'h0, st});
    chk("tx", 32'h0, {23'h0, tx});
    read_reg("config", 14'h0008, 32'h0);
    read_reg("unmapped", 14'h0040, 32'h0);
    $display("start test done");
  endtask : t_start
  task automatic t_config();
    write_reg(14'h0008, 32'h21);
    repeat (2) @(posedge i_clock);
    #1;
    chk("tx comma", {23'h0, 8'hbc, 1'b1}, {23'h0, tx});
    read_reg("config", 14'h0008, 32'h21);
    $display("config test done");
  endtask : t_config
  task automatic t_refuse();
    write_reg(14'h0008, 32'h25);
    repeat (2) @(posedge i_clock);
    #1;
    chk("loop idle", 32'h0, {23'h0, tx});
    write_reg(14'h0040, 32'h0);
    read_reg("config kept", 14'h0008, 32'h25);
    write_reg(14'h0008, 32'h21);
    repeat (2) @(posedge i_clock);
    #1;
    chk("tx comma again", {23'h0, 8'hbc, 1'b1}, {23'h0, tx});
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_sync();
    @(posedge i_clock);
    send <= 1'b1;
    wait_status(8'h02);
    wait_status(8'h07);
    wait_status(8'h87);
    wait_status(8'hc7);
    @(posedge i_clock);
    #1;
    chk("readies", 32'hff, {24'h0, lr, dr, txr, rxr});
    read_reg("status reg", 14'h000c, 32'hc7);
    $display("sync test done");
  endtask : t_sync
  task automatic t_loss();
    @(posedge i_clock);
    send <= 1'b0;
    wait_status(8'h00);
    @(posedge i_clock);
    #1;
    chk("link ready", 32'h0, {31'h0, lr});
    $display("loss test done");
  endtask : t_loss
  task automatic t_slave();
    @(posedge i_clock);
    rst <= 1'b1;
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    read_reg("config", 14'h0008, 32'h0);
    write_reg(14'h0008, 32'h31);
    repeat (20) @(posedge i_clock);
    #1;
    chk("slave quiet", 32'h0, {31'h0, tx.is_k});
    @(posedge i_clock);
    send <= 1'b1;
    wait_status(8'h02);
    repeat (3) @(posedge i_clock);
    #1;
    chk("slave comma", {23'h0, 8'hbc, 1'b1}, {23'h0, tx});
    $display("slave test done");
  endtask : t_slave
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    t_start();
    t_config();
    t_refuse();
    t_sync();
    t_loss();
    t_slave();
    conclude();
  end
endmodule : test_rlis_link_core
